// *** exs_sequencer.sv ***
// Purpose: exception sequencer: save status, find vector, push frame,
//          fetch the handler address and start the handler fetch
// Assumes: single core clock; core bus slave never errors here
// Notes:   one core bus request at a time, held until acknowledged
`timescale 1ns/1ns
`default_nettype none
module exs_sequencer
    import exs_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    // exception request from the pipeline
    input  wire logic        exc_req_in,
    input  wire logic        exc_irq_in,
    input  wire logic [7:0]  exc_vec_in,
    input  wire logic [2:0]  exc_level_in,
    input  wire logic [3:0]  exc_fs_in,
    input  wire logic [31:0] exc_pc_in,
    input  wire logic [31:0] exc_next_pc_in,
    input  wire logic        first_instr_done_in,
    output logic             busy_out,
    output logic             fetch_req_out,
    output logic [31:0]      fetch_addr_out,
    output logic             irq_inhibit_out,
    output logic [15:0]      status_word_out,
    // core bus master
    output logic             bus_req_out,
    output logic             bus_we_out,
    output logic             bus_interrupt_acknowledge_cycle_out,
    output logic [31:0]      bus_addr_out,
    output logic [31:0]      bus_wdata_out,
    input  wire logic        bus_ack_in,
    input  wire logic [31:0] bus_rdata_in,
    // register port
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        exs_state_e  st;
        logic [15:0] sw;
        logic [15:0] sw_copy;
        logic [31:0] supervisor_stack_pointer;
        logic [31:0] usp;
        logic [11:0] tbase;
        logic [7:0]  vec;
        logic [3:0]  fs;
        logic        irq;
        logic [2:0]  level;
        logic [31:0] pc;
        logic [3:0]  fmt;
        logic        breq;
        logic        bwe;
        logic        biack;
        logic [31:0] baddr;
        logic [31:0] bwdata;
        logic        freq;
        logic [31:0] faddr;
        logic        inhibit;
        logic [31:0] rdata;
    } exs_state_s;

    exs_state_s r_reg;
    exs_state_s r_next;

    // traps stack next
    // stacked PC is next for trace, debug, spurious, traps, peripherals
    function automatic logic next_type(input logic [7:0] v);
        next_type = (v == VEC_TRACE) || (v == VEC_DEBUG)
                 || (v == VEC_SPUR) || (v >= VEC_DEV_LO)
                 || ((v >= VEC_TRAP_LO) && (v <= VEC_TRAP_HI));
    endfunction : next_type

    // defined fault codes
    // keep only defined fault codes for access and address errors
    function automatic logic [3:0] fs_code(input logic [7:0] v,
                                           input logic [3:0] f);
        fs_code = FS_NONE;
        if ((v == VEC_ACCESS) || (v == VEC_ADDRESS)) begin
            if ((f == FS_IFETCH) || (f == FS_OWRITE)
                || (f == FS_WPROT) || (f == FS_OREAD)) begin
                fs_code = f;
            end
        end
    endfunction : fs_code

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.freq  = 1'b0;
        // register writes from software
        if (reg_wr_in) begin
            if (reg_addr_in == REG_TBASE) begin
                r_next.tbase = reg_wdata_in[31:TBASE_LSB];
            end else if (reg_addr_in == REG_SSP) begin
                r_next.supervisor_stack_pointer = reg_wdata_in;
            end else if (reg_addr_in == REG_USP) begin
                r_next.usp = reg_wdata_in;
            end else if (reg_addr_in == REG_STATUS) begin
                r_next.sw = reg_wdata_in[15:0];
            end
        end
        // register reads, data valid next cycle
        r_next.rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            if (reg_addr_in == REG_TBASE) begin
                r_next.rdata = {r_reg.tbase, 20'h00000};
            end else if (reg_addr_in == REG_SSP) begin
                r_next.rdata = r_reg.supervisor_stack_pointer;
            end else if (reg_addr_in == REG_USP) begin
                r_next.rdata = r_reg.usp;
            end else if (reg_addr_in == REG_STATUS) begin
                r_next.rdata = {16'h0000, r_reg.sw};
            end else if (reg_addr_in == REG_STATE) begin
                r_next.rdata = {20'h00000, r_reg.vec,
                                r_reg.inhibit, r_reg.st};
            end
        end
        // inhibit until first handler instruction ends
        if (first_instr_done_in) begin
            r_next.inhibit = 1'b0;
        end
        case (r_reg.st)
            EXS_IDLE: begin
                // vectors 0 and 1 never stacked except for interrupts
                if (exc_req_in
                    && (exc_irq_in || (exc_vec_in > VEC_INIT_PC))) begin
                    r_next.st    = EXS_SAVE;
                    r_next.irq   = exc_irq_in;
                    r_next.level = exc_level_in;
                    r_next.vec   = exc_vec_in;
                    r_next.fs    = exc_irq_in ? FS_NONE
                                 : fs_code(exc_vec_in, exc_fs_in);
                    r_next.pc    = (exc_irq_in || next_type(exc_vec_in))
                                 ? exc_next_pc_in : exc_pc_in;
                end
            end
            EXS_SAVE: begin
                r_next.sw_copy         = r_reg.sw;
                r_next.sw[SW_S_BIT]    = 1'b1;
                r_next.sw[SW_T_BIT]    = 1'b0;
                // format from stack pointer low bits
                r_next.fmt = FMT_BASE | {2'b00, r_reg.supervisor_stack_pointer[1:0]};
                if (r_reg.irq) begin
                    r_next.sw[SW_M_BIT]            = 1'b0;
                    r_next.sw[SW_I_LSB+2:SW_I_LSB] = r_reg.level;
                    r_next.st     = EXS_INTERRUPT_ACKNOWLEDGE_CYCLE;
                    r_next.breq   = 1'b1;
                    r_next.bwe    = 1'b0;
                    r_next.biack  = 1'b1;
                    r_next.baddr  = INTERRUPT_ACKNOWLEDGE_CYCLE_BASE
                                  | {27'h0, r_reg.level, 2'b00};
                end else begin
                    r_next.st     = EXS_PUSH_PC;
                    r_next.breq   = 1'b1;
                    r_next.bwe    = 1'b1;
                    r_next.biack  = 1'b0;
                    r_next.baddr  = {r_reg.supervisor_stack_pointer[31:2], 2'b00} - LONG_LEN;
                    r_next.bwdata = r_reg.pc;
                end
            end
            EXS_INTERRUPT_ACKNOWLEDGE_CYCLE: begin
                if (bus_ack_in) begin
                    r_next.vec    = bus_rdata_in[7:0];
                    r_next.st     = EXS_PUSH_PC;
                    r_next.bwe    = 1'b1;
                    r_next.biack  = 1'b0;
                    r_next.baddr  = {r_reg.supervisor_stack_pointer[31:2], 2'b00} - LONG_LEN;
                    r_next.bwdata = r_reg.pc;
                end
            end
            EXS_PUSH_PC: begin
                if (bus_ack_in) begin
                    r_next.st     = EXS_PUSH_FV;
                    r_next.baddr  = r_reg.baddr - LONG_LEN;
                    r_next.bwdata = {r_reg.fmt, r_reg.fs[3:2],
                                     r_reg.vec, r_reg.fs[1:0],
                                     r_reg.sw_copy};
                end
            end
            EXS_PUSH_FV: begin
                if (bus_ack_in) begin
                    r_next.supervisor_stack_pointer   = r_reg.baddr;
                    // vector read at base plus 4*vector
                    r_next.st    = EXS_VFETCH;
                    r_next.bwe   = 1'b0;
                    r_next.baddr = {r_reg.tbase, 10'h000,
                                    r_reg.vec, 2'b00};
                end
            end
            EXS_VFETCH: begin
                if (bus_ack_in) begin
                    r_next.breq = 1'b0;
                    if (bus_rdata_in[0]) begin
                        r_next.st  = EXS_SAVE;
                        r_next.irq = 1'b0;
                        r_next.vec = VEC_ADDRESS;
                        r_next.fs  = FS_NONE;
                    end else begin
                        r_next.st    = EXS_HANDLER;
                        r_next.faddr = bus_rdata_in;
                    end
                end
            end
            EXS_HANDLER: begin
                r_next.freq    = 1'b1;
                r_next.inhibit = 1'b1;
                r_next.st      = EXS_IDLE;
            end
            default: begin
                r_next.st = EXS_IDLE;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r_reg    <= '0;
            r_reg.st <= EXS_IDLE;
            r_reg.sw <= SW_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign busy_out        = (r_reg.st != EXS_IDLE);
    assign fetch_req_out   = r_reg.freq;
    assign fetch_addr_out  = r_reg.faddr;
    assign irq_inhibit_out = r_reg.inhibit;
    assign status_word_out = r_reg.sw;
    assign bus_req_out     = r_reg.breq;
    assign bus_we_out      = r_reg.bwe;
    assign bus_interrupt_acknowledge_cycle_out    = r_reg.biack;
    assign bus_addr_out    = r_reg.baddr;
    assign bus_wdata_out   = r_reg.bwdata;
    assign reg_rdata_out   = r_reg.rdata;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    property p_sup_entry;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_SAVE) |=>
            r_reg.sw[SW_S_BIT] && !r_reg.sw[SW_T_BIT]
            && (r_reg.sw_copy == $past(r_reg.sw));
    endproperty
    a_sup_entry: assert property (p_sup_entry)
        else $error("supervisor entry wrong");

    property p_irq_mask;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_SAVE && r_reg.irq) |=>
            !r_reg.sw[SW_M_BIT]
            && r_reg.sw[SW_I_LSB+2:SW_I_LSB] == $past(r_reg.level);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt mask not loaded");

    property p_no_interrupt_acknowledge_cycle_fault;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_SAVE && !r_reg.irq) |=>
            !bus_interrupt_acknowledge_cycle_out && bus_we_out;
    endproperty
    a_no_interrupt_acknowledge_cycle_fault: assert property (p_no_interrupt_acknowledge_cycle_fault)
        else $error("fault ran acknowledge cycle");

    property p_aligned;
        @(posedge mclk_in) disable iff (!nrst_in)
        (bus_req_out && bus_we_out) |-> bus_addr_out[1:0] == 2'b00;
    endproperty
    a_aligned: assert property (p_aligned)
        else $error("frame write not aligned");

    property p_fmt;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_PUSH_FV && bus_req_out) |->
            bus_wdata_out[31:28] == (FMT_BASE | {2'b00, r_reg.supervisor_stack_pointer[1:0]});
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format field wrong");

    property p_fs_zero;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_PUSH_FV && r_reg.vec != VEC_ACCESS
         && r_reg.vec != VEC_ADDRESS) |->
            {bus_wdata_out[27:26], bus_wdata_out[17:16]} == 4'h0;
    endproperty
    a_fs_zero: assert property (p_fs_zero)
        else $error("fault status not zero");

    property p_vec_addr;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_VFETCH) |->
            bus_addr_out == {r_reg.tbase, 10'h000, r_reg.vec, 2'b00};
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("vector address wrong");

    property p_sp_end;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_PUSH_FV && bus_ack_in) |=>
            r_reg.supervisor_stack_pointer == ({$past(r_reg.supervisor_stack_pointer[31:2]), 2'b00} - FRAME_LEN);
    endproperty
    a_sp_end: assert property (p_sp_end)
        else $error("stack pointer not at frame");

    property p_inhibit;
        @(posedge mclk_in) disable iff (!nrst_in)
        fetch_req_out |-> irq_inhibit_out;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("interrupts not inhibited");

    property p_done;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_HANDLER) |=> fetch_req_out && !busy_out;
    endproperty
    a_done: assert property (p_done)
        else $error("handler fetch not issued");

    property p_no_reset_vec;
        @(posedge mclk_in) disable iff (!nrst_in)
        (r_reg.st == EXS_IDLE && exc_req_in && !exc_irq_in
         && exc_vec_in <= VEC_INIT_PC) |=> !busy_out;
    endproperty
    a_no_reset_vec: assert property (p_no_reset_vec)
        else $error("reset vector taken as exception");
endmodule : exs_sequencer
`default_nettype wire

// *** exs_pkg.sv ***
// Purpose: constants for the exception sequencer
// Assumes: 32-bit core bus, word-indexed register port
// Notes:   status word bit positions follow the core's layout
`default_nettype none
package exs_pkg;
    // -----------------------------------------------------------------
    // status word fields
    // -----------------------------------------------------------------
    localparam int SW_T_BIT   = 15;
    localparam int SW_S_BIT   = 13;
    localparam int SW_M_BIT   = 12;
    localparam int SW_I_LSB   = 8;
    localparam logic [15:0] SW_RESET = 16'h2700;

    // -----------------------------------------------------------------
    // register port indices
    // -----------------------------------------------------------------
    localparam logic [2:0] REG_TBASE  = 3'h0;
    localparam logic [2:0] REG_SSP    = 3'h1;
    localparam logic [2:0] REG_USP    = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_STATE  = 3'h4;

    // -----------------------------------------------------------------
    // vectors, frame and fault codes
    // -----------------------------------------------------------------
    localparam logic [7:0] VEC_INIT_PC = 8'h01;
    localparam logic [7:0] VEC_ACCESS  = 8'h02;
    localparam logic [7:0] VEC_ADDRESS = 8'h03;
    localparam logic [7:0] VEC_TRACE   = 8'h09;
    localparam logic [7:0] VEC_DEBUG   = 8'h0C;
    localparam logic [7:0] VEC_SPUR    = 8'h18;
    localparam logic [7:0] VEC_TRAP_LO = 8'h20;
    localparam logic [7:0] VEC_TRAP_HI = 8'h2F;
    localparam logic [7:0] VEC_DEV_LO  = 8'h40;
    localparam logic [3:0] FMT_BASE    = 4'h4;
    localparam logic [3:0] FS_IFETCH   = 4'h4;
    localparam logic [3:0] FS_OWRITE   = 4'h8;
    localparam logic [3:0] FS_WPROT    = 4'h9;
    localparam logic [3:0] FS_OREAD    = 4'hC;
    localparam logic [3:0] FS_NONE     = 4'h0;
    localparam logic [31:0] FRAME_LEN  = 32'h0000_0008;
    localparam logic [31:0] LONG_LEN   = 32'h0000_0004;
    localparam int TBASE_LSB = 20;
    localparam logic [31:0] INTERRUPT_ACKNOWLEDGE_CYCLE_BASE  = 32'hFFFF_FFE0;

    typedef enum logic [2:0] {
        EXS_IDLE, EXS_SAVE, EXS_INTERRUPT_ACKNOWLEDGE_CYCLE, EXS_PUSH_PC,
        EXS_PUSH_FV, EXS_VFETCH, EXS_HANDLER
    } exs_state_e;
endpackage : exs_pkg
`default_nettype wire

// *** exs_bus_model.sv ***
// Purpose: core bus slave: memory plus interrupt controller answers
// Assumes: one request at a time, held until acknowledged
// Notes:   read data wander outside the acknowledge cycle
`timescale 1ns/1ns
`default_nettype none
module exs_bus_model (
    input  wire logic        mclk_in,
    input  wire logic        bus_req_in,
    input  wire logic        bus_we_in,
    input  wire logic        bus_interrupt_acknowledge_cycle_in,
    input  wire logic [31:0] bus_addr_in,
    input  wire logic [31:0] bus_wdata_in,
    input  wire logic [3:0]  dly_in,
    input  wire logic [7:0]  ack_vec_in,
    output logic             bus_ack_out,
    output logic [31:0]      bus_rdata_out
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] ack_addr;
    logic [3:0]  wait_cnt = 4'h0;
    initial bus_ack_out = 1'b0;
    initial bus_rdata_out = 32'h0;
    // -----------------------------------------------------------------
    // answer after dly_in idle cycles, for one cycle only
    // -----------------------------------------------------------------
    always @(posedge mclk_in) begin
        bus_ack_out <= 1'b0;
        bus_rdata_out <= ~bus_rdata_out; // no stale data outside ack
        if (bus_req_in && !bus_ack_out) begin
            if (wait_cnt < dly_in) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                wait_cnt <= 4'h0;
                bus_ack_out <= 1'b1;
                if (bus_interrupt_acknowledge_cycle_in) begin
                    ack_addr <= bus_addr_in;
                    bus_rdata_out <= {24'h0, ack_vec_in};
                end else if (bus_we_in) begin
                    mem[bus_addr_in] = bus_wdata_in;
                end else begin
                    bus_rdata_out <= mem.exists(bus_addr_in) ?
                                     mem[bus_addr_in] : 32'h0;
                end
            end
        end
    end
endmodule : exs_bus_model
`default_nettype wire

// *** test_cpu_exception_sequencer.sv ***
// Purpose: self-checking bench for the exception sequencer
// Assumes: bus model answers every access, table base 0010_0000h
// Notes:   stacked PC is 2000h (fault) or 2004h (next) throughout
`timescale 1ns/1ns
`default_nettype none
module test_cpu_exception_sequencer;
    import exs_pkg::*;
    logic        mclk_in, nrst_in, exc_req_in, exc_irq_in;
    logic [7:0]  exc_vec_in, ack_vec;
    logic [2:0]  exc_level_in, reg_addr_in;
    logic [3:0]  exc_fs_in, dly;
    logic        first_instr_done_in, reg_wr_in, reg_rd_in, bus_ack_in;
    logic [31:0] reg_wdata_in, bus_rdata_in, bus_addr_out, bus_wdata_out;
    logic        busy_out, fetch_req_out, irq_inhibit_out;
    logic        bus_req_out, bus_we_out, bus_interrupt_acknowledge_cycle_out;
    logic [31:0] fetch_addr_out, reg_rdata_out, got, v;
    logic [15:0] status_word_out;
    int          error_cnt = 0, checks = 0, cyc = 0;

    exs_sequencer dut_u (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .exc_req_in(exc_req_in),
        .exc_irq_in(exc_irq_in), .exc_vec_in(exc_vec_in),
        .exc_level_in(exc_level_in), .exc_fs_in(exc_fs_in),
        .exc_pc_in(32'h0000_2000), .exc_next_pc_in(32'h0000_2004),
        .first_instr_done_in(first_instr_done_in), .busy_out(busy_out),
        .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out),
        .irq_inhibit_out(irq_inhibit_out),
        .status_word_out(status_word_out), .bus_req_out(bus_req_out),
        .bus_we_out(bus_we_out), .bus_interrupt_acknowledge_cycle_out(bus_interrupt_acknowledge_cycle_out),
        .bus_addr_out(bus_addr_out), .bus_wdata_out(bus_wdata_out),
        .bus_ack_in(bus_ack_in), .bus_rdata_in(bus_rdata_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out));
    exs_bus_model bus_u (
        .mclk_in(mclk_in), .bus_req_in(bus_req_out), .bus_we_in(bus_we_out),
        .bus_interrupt_acknowledge_cycle_in(bus_interrupt_acknowledge_cycle_out), .bus_addr_in(bus_addr_out),
        .bus_wdata_in(bus_wdata_out), .dly_in(dly), .ack_vec_in(ack_vec),
        .bus_ack_out(bus_ack_in), .bus_rdata_out(bus_rdata_in));

    // -----------------------------------------------------------------
    // clock, cycle ceiling, shared tasks
    // -----------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_rd
    // start one exception and wait for the handler fetch
    task automatic run_exc(input logic irq, input logic [7:0] vec,
        input logic [2:0] lvl, input logic [3:0] fs, input logic [31:0] sp);
        int n;
        logic seen;
        reg_wr(3'h1, sp);
        @(posedge mclk_in);
        exc_req_in <= 1'b1;
        exc_irq_in <= irq;
        exc_vec_in <= vec;
        exc_level_in <= lvl;
        exc_fs_in <= fs;
        @(posedge mclk_in);
        exc_req_in <= 1'b0;
        n = 0;
        seen = 1'b0;
        while (n < 300 && seen !== 1'b1) begin
            @(posedge mclk_in);
            #1 seen = fetch_req_out;
            n++;
        end
        chk(seen, 1'b1);
        got = fetch_addr_out;
    endtask : run_exc

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_regs();
        reg_wr(REG_TBASE, 32'h0012_3456);
        reg_rd(REG_TBASE, v);
        chk(v, 32'h0010_0000);
        reg_rd(3'h7, v);
        chk(v, 32'h0);
        @(posedge mclk_in);
        exc_req_in <= 1'b1;
        exc_vec_in <= 8'h01;
        @(posedge mclk_in);
        exc_req_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk(busy_out, 1'b0);
    endtask : t_regs
    task automatic t_fault();
        bus_u.mem[32'h0010_0008] = 32'h0000_3000;
        reg_wr(REG_STATUS, 32'h8000);
        reg_wr(REG_USP, 32'h5000);
        run_exc(1'b0, 8'h02, 3'h0, 4'h8, 32'h1000);
        chk(got, 32'h3000);
        chk(irq_inhibit_out, 1'b1);
        chk(bus_u.mem[32'h0FFC], 32'h2000);
        chk(bus_u.mem[32'h0FF8], 32'h4808_8000);
        chk(status_word_out, 16'h2000);
        reg_rd(3'h1, v);
        chk(v, 32'h0FF8);
        reg_rd(REG_USP, v);
        chk(v, 32'h5000);
        @(posedge mclk_in);
        first_instr_done_in <= 1'b1;
        @(posedge mclk_in);
        first_instr_done_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk(irq_inhibit_out, 1'b0);
    endtask : t_fault
    task automatic t_trap();
        bus_u.mem[32'h0010_0080] = 32'h0000_3200;
        run_exc(1'b0, 8'h20, 3'h0, 4'h9, 32'h1001);
        chk(got, 32'h3200);
        chk(bus_u.mem[32'h0FFC], 32'h2004);
        chk(bus_u.mem[32'h0FF8], 32'h5080_2000);
        reg_rd(3'h1, v);
        chk(v, 32'h0FF8);
    endtask : t_trap
    task automatic t_irq();
        bus_u.mem[32'h0010_0114] = 32'h0000_3400;
        dly = 4'h3;
        ack_vec = 8'h45;
        reg_wr(REG_STATUS, 32'h9000);
        run_exc(1'b1, 8'h02, 3'h5, 4'h8, 32'h2002);
        chk(bus_u.ack_addr, 32'hFFFF_FFF4);
        chk(got, 32'h3400);
        chk(bus_u.mem[32'h1FFC], 32'h2004);
        chk(bus_u.mem[32'h1FF8], 32'h6114_9000);
        chk(status_word_out, 16'h2500);
        dly = 4'h0;
    endtask : t_irq
    task automatic t_odd();
        bus_u.mem[32'h0010_0010] = 32'h0000_4001;
        bus_u.mem[32'h0010_000C] = 32'h0000_4100;
        run_exc(1'b0, 8'h04, 3'h0, 4'h0, 32'h3000);
        chk(got, 32'h4100);
        reg_rd(3'h1, v);
        chk(v, 32'h2FF0);
        chk(bus_u.mem[32'h2FF0][25:18], 8'h03);
    endtask : t_odd

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        nrst_in = 1'b0;
        exc_req_in = 1'b0;
        exc_irq_in = 1'b0;
        exc_vec_in = 8'h0;
        exc_level_in = 3'h0;
        exc_fs_in = 4'h0;
        first_instr_done_in = 1'b0;
        reg_addr_in = 3'h0;
        reg_wdata_in = 32'h0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        dly = 4'h0;
        ack_vec = 8'h0;
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        t_regs();
        t_fault();
        t_trap();
        t_irq();
        t_odd();
        finish_test();
    end
endmodule : test_cpu_exception_sequencer
`default_nettype wire
